// file: test/tscw_core_bench.sv
// self-checking bench for the trimmed seconds counter with watchdog
`timescale 1ns/1ps
`include "tscw_consts.svh"
`define CHECK_EQ(got, exp) begin checks_done++; if ((got) !== (exp)) begin bad_count++; $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module tscw_core_bench;
    // ======================================================================
    // signals
    // short divider values keep the run small; expectations derive from them
    localparam int HTS = 4;
    localparam int WDS = 4;
    localparam int MDIV = 3;
    localparam int TIMEOUT = 20000;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic slow_tick_i = 1'b0;
    logic mclk_tick_i = 1'b0;
    logic usb_event_i = 1'b0;
    logic keypad_event_i = 1'b0;
    tscw_pkg::tscw_bus_t bus_i = '0;
    logic [7:0] rdata_o;
    logic ext_irq5_o;
    logic wdog_reset_o;
    logic powerdown_mux_ctrl_o;
    int bad_count = 0;
    int checks_done = 0;
    int cycles = 0;
    int wd_count = 0;
    logic [31:0] seed = 32'h44;
    logic [7:0] d;
    int e;
    int codes [6] = '{0, 3, 4, 5, 6, 7};
    int lens [6] = '{8, 8, 4, 16, 32, 64};
    int hits [$];
    // ======================================================================
    // clock, design, watchdog pulse count
    always #2.5 clock_i = ~clock_i;
    tscw_core #(.HALF_TICK_SLOW(HTS), .MCLK_DIV(MDIV), .WDOG_SLOW(WDS)) tscw_core_i (
        .clock_i(clock_i), .rst_i(rst_i), .slow_tick_i(slow_tick_i),
        .mclk_tick_i(mclk_tick_i), .bus_i(bus_i), .rdata_o(rdata_o),
        .usb_event_i(usb_event_i), .keypad_event_i(keypad_event_i),
        .ext_irq5_o(ext_irq5_o), .wdog_reset_o(wdog_reset_o),
        .powerdown_mux_ctrl_o(powerdown_mux_ctrl_o));
    always @(posedge clock_i) begin
        cycles++;
        if (wdog_reset_o === 1'b1) wd_count++;
        if (cycles == TIMEOUT) begin
            bad_count++;
            wrap_up();
        end
    end
    // ======================================================================
    // tasks
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task wrap_up;
        $display("checks done %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task do_reset;
        @(posedge clock_i) rst_i <= 1'b1;
        repeat (5) @(posedge clock_i);
        rst_i <= 1'b0;
        wd_count = 0;
    endtask
    task wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge clock_i);
        bus_i.addr <= a;
        bus_i.wdata <= v;
        bus_i.wr <= 1'b1;
        @(posedge clock_i);
        bus_i.wr <= 1'b0;
    endtask
    task rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge clock_i);
        bus_i.addr <= a;
        bus_i.rd <= 1'b1;
        @(posedge clock_i);
        bus_i.rd <= 1'b0;
        #1 v = rdata_o;
    endtask
    // one slow edge either way: one oscillator pulse, or MDIV master pulses
    task step(input int n);
        repeat (n) for (int k = 0; k < MDIV; k++) begin
            @(posedge clock_i);
            slow_tick_i <= (k == 0);
            mclk_tick_i <= 1'b1;
            @(posedge clock_i);
            slow_tick_i <= 1'b0;
            mclk_tick_i <= 1'b0;
        end
    endtask
    // checked mid-period, so a one-edge phase choice cannot matter
    task count_case(input logic [7:0] sel, input int p, input logic [23:0] acc,
                    input logic [23:0] trim, input bit mclk);
        logic [31:0] v;
        logic [31:0] exp_cnt;
        logic [24:0] a;
        do_reset();
        if (mclk) wr(`TSCW_OFF_OSC, 8'h00); // oscillator off
        v = rnd();
        for (int i = 0; i < 4; i++) wr(`TSCW_OFF_CNT0 + 16'(i), v[8*i +: 8]);
        for (int i = 0; i < 3; i++) begin
            wr(`TSCW_OFF_ACC0 + 16'(i), acc[8*i +: 8]);
            wr(`TSCW_OFF_TRIM0 + 16'(i), trim[8*i +: 8]);
        end
        wr(`TSCW_OFF_CTRL, sel | 8'h20);
        rd(`TSCW_OFF_CTRL, d);
        `CHECK_EQ(d, sel | 8'h20) // load waits for slow edge
        step(3 * p + p / 2);
        exp_cnt = v;
        a = {1'b0, acc};
        for (int i = 0; i < 3; i++) begin
            a = a + {2'b00, trim[22:0]};
            if (a[24]) begin
                a[24] = 1'b0;
                exp_cnt += trim[23] ? 32'd0 : 32'd2;
            end else begin
                exp_cnt += 32'd1;
            end
        end
        for (int i = 0; i < 4; i++) begin
            rd(`TSCW_OFF_CNT0 + 16'(i), d);
            `CHECK_EQ(d, exp_cnt[8*i +: 8]) // count after periods
        end
        for (int i = 0; i < 3; i++) begin
            rd(`TSCW_OFF_ACC0 + 16'(i), d);
            `CHECK_EQ(d, a[8*i +: 8]) // accumulator
            rd(`TSCW_OFF_TRIM0 + 16'(i), d);
            `CHECK_EQ(d, trim[8*i +: 8]) // loaded trim
        end
    endtask
    // ======================================================================
    // main sequence
    initial begin
        do_reset();
        rd(`TSCW_OFF_SHARED, d);
        `CHECK_EQ(d, 8'h00) // shared reset value
        rd(`TSCW_OFF_CTRL, d);
        `CHECK_EQ(d, 8'h00) // default selects
        rd(16'hff50, d);
        `CHECK_EQ(d, 8'h00) // unmapped reads zero
        wr(`TSCW_OFF_SHARED, 8'hff);
        rd(`TSCW_OFF_SHARED, d);
        `CHECK_EQ(d, 8'haa) // flags not writable
        `CHECK_EQ(powerdown_mux_ctrl_o, 1'b1) // mux control bit
        `CHECK_EQ(ext_irq5_o, 1'b0) // no flags, no request
        @(posedge clock_i) usb_event_i <= 1'b1;
        @(posedge clock_i) usb_event_i <= 1'b0;
        #1 `CHECK_EQ(ext_irq5_o, 1'b1) // shared line
        @(posedge clock_i) keypad_event_i <= 1'b1;
        @(posedge clock_i) keypad_event_i <= 1'b0;
        rd(`TSCW_OFF_SHARED, d);
        `CHECK_EQ(d, 8'haf) // other flags
        // every period select, then positive, negative and master-clock trims
        count_case(8'h00, 8, 24'h0, 24'h0, 1'b0); // one second
        count_case(8'h08, 8, 24'h0, 24'h0, 1'b0); // one second alt
        count_case(8'h10, 4, 24'h0, 24'h0, 1'b0); // half second
        count_case(8'h18, 16, 24'h0, 24'h0, 1'b0); // two seconds
        count_case(8'h10, 4, 24'hffff00, 24'h000080, 1'b0); // positive
        count_case(8'h10, 4, 24'hffff00, 24'h800080, 1'b0); // negative
        count_case(8'h00, 8, 24'hfffffe, 24'h0006fd, 1'b1); // master clock
        // interval spacing measured between the second and third flag
        do_reset();
        for (int c = 0; c < 6; c++) begin
            wr(`TSCW_OFF_CTRL, 8'(codes[c]));
            rd(`TSCW_OFF_SHARED, d);
            hits.delete();
            e = 0;
            while (hits.size() < 3 && e < 3 * lens[c] + 8) begin
                step(1);
                e++;
                rd(`TSCW_OFF_SHARED, d);
                if (d[4] === 1'b1) hits.push_back(e);
            end
            `CHECK_EQ(hits.size() == 3 ? hits[2] - hits[1] : -1, lens[c]) // interval
        end
        // unserviced interrupt must bring the reset request
        do_reset();
        wr(`TSCW_OFF_SHARED, 8'h20);
        wr(`TSCW_OFF_CTRL, 8'h04);
        e = 0;
        while (ext_irq5_o !== 1'b1 && e < 12) begin
            step(1);
            #1 e++;
        end
        `CHECK_EQ(ext_irq5_o, 1'b1) // flag and enable
        step(3);
        `CHECK_EQ(wd_count, 0) // not before half second
        step(1);
        `CHECK_EQ(wd_count, 1) // reset request
        do_reset();
        wr(`TSCW_OFF_SHARED, 8'h20);
        wr(`TSCW_OFF_CTRL, 8'h04);
        repeat (24) begin
            step(1);
            rd(`TSCW_OFF_SHARED, d);
        end
        `CHECK_EQ(wd_count, 0) // read services
        do_reset();
        wr(`TSCW_OFF_CTRL, 8'h04);
        step(24);
        #1 `CHECK_EQ(ext_irq5_o, 1'b0) // enable gates
        `CHECK_EQ(wd_count, 0) // masked means no watchdog
        rd(`TSCW_OFF_SHARED, d);
        `CHECK_EQ(d[4], 1'b1) // flag still pending
        wrap_up();
    end
endmodule // tscw_core_bench

// file: verilog/tscw_consts.svh
// constants for the trimmed seconds counter with watchdog
`ifndef TSCW_CONSTS_SVH
`define TSCW_CONSTS_SVH
// ======================================================================
// register offsets (byte addresses)
`define TSCW_OFF_SHARED 16'hff94
`define TSCW_OFF_CTRL 16'hff40
`define TSCW_OFF_CNT0 16'hff41
`define TSCW_OFF_CNT1 16'hff42
`define TSCW_OFF_CNT2 16'hff43
`define TSCW_OFF_CNT3 16'hff44
`define TSCW_OFF_ACC0 16'hff45
`define TSCW_OFF_ACC1 16'hff46
`define TSCW_OFF_ACC2 16'hff47
`define TSCW_OFF_TRIM0 16'hff48
`define TSCW_OFF_TRIM1 16'hff49
`define TSCW_OFF_TRIM2 16'hff4a
`define TSCW_OFF_OSC 16'hff4b
// ======================================================================
// field positions
`define TSCW_BIT_LOAD 5
`define TSCW_BIT_PERIOD_HI 4
`define TSCW_BIT_PERIOD_LO 3
`define TSCW_BIT_INTERVAL_HI 2
`define TSCW_BIT_PD_MUX 7
`define TSCW_BIT_RTC_IEN 5
`define TSCW_BIT_RTC_FLAG 4
`define TSCW_BIT_USB_IEN 3
`define TSCW_BIT_USB_FLAG 2
`define TSCW_BIT_KP_IEN 1
`define TSCW_BIT_KP_FLAG 0
`define TSCW_TRIM_SIGN 23
// ======================================================================
// reset values
`define TSCW_RST_SHARED 8'h00
`define TSCW_RST_CTRL 8'h00
`define TSCW_RST_OSC 8'h01
// ======================================================================
// timing
`define TSCW_CLK_MHZ 200
`define TSCW_SLOW_HZ 32768
`define TSCW_HALF_SEC_SLOW (`TSCW_SLOW_HZ / 2)
`define TSCW_MCLK_MHZ 96
`define TSCW_MCLK_DIV 2930
`define TSCW_WDOG_MS 500
`endif

// file: verilog/tscw_core.sv
// trimmed seconds counter, periodic interrupt and hardware watchdog
// ======================================================================
// How it works
// - slow clock divided to half-second ticks
// - no crystal: master clock divided by 2930
// - 32-bit counter, four byte registers
// - period select: 0x 1s, 10 half, 11 2s
// - trim magnitude accumulated each counter period
// - trim is 24-bit sign-magnitude, three bytes
// - positive overflow adds one extra count
// - negative overflow suppresses that advance
// - load bit copies staged values on slow edge
// - interrupt interval 0.5 to 8 seconds
// - interrupt goes to external interrupt 5
// - enable bit 5, flag bit 4 read-clear
// - shared register resets to zero
// - unserviced interrupt for half second resets
// - watchdog only while interrupt enabled
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`include "tscw_consts.svh"
module tscw_core #(
    parameter int HALF_TICK_SLOW = `TSCW_HALF_SEC_SLOW,
    parameter int MCLK_DIV = `TSCW_MCLK_DIV,
    parameter int WDOG_SLOW = `TSCW_HALF_SEC_SLOW
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // slow oscillator edge (one-cycle pulse per 32768 hz period)
    input wire logic slow_tick_i,
    // master clock divided edge source (one-cycle pulse per 96 mhz cycle)
    input wire logic mclk_tick_i,
    // register port
    input wire tscw_pkg::tscw_bus_t bus_i,
    output logic [7:0] rdata_o,
    // shared flags from other blocks
    input wire logic usb_event_i,
    input wire logic keypad_event_i,
    // outputs
    output logic ext_irq5_o,
    output logic wdog_reset_o,
    output logic powerdown_mux_ctrl_o
);
    // ==================================================================
    // parameter checks
    // dividers are 12 and 16 bits wide, larger counts cannot be served
    if (HALF_TICK_SLOW < 2 || HALF_TICK_SLOW > 65536 || MCLK_DIV < 2 || MCLK_DIV > 4096
            || WDOG_SLOW < 1 || WDOG_SLOW > 65536) begin : g_param_check
        $error("tscw_core: parameter out of range");
    end

    // ==================================================================
    // registers
    logic [7:0] shared_event_enable_flags;
    logic [7:0] timekeeping_control;
    logic osc_enable;
    logic [31:0] time_count, staged_count;
    logic [23:0] trim_accumulator, staged_acc;
    logic [23:0] trim_value, staged_trim;
    logic load_pending;
    logic [11:0] mdiv;
    logic [15:0] slow_div;
    logic [3:0] half_cnt_period, half_cnt_irq;
    logic [15:0] wdog_cnt;
    tscw_pkg::tscw_wdog_t wdog_state;

    logic wr_shared, rd_shared;
    assign wr_shared = bus_i.wr && bus_i.addr == `TSCW_OFF_SHARED;
    assign rd_shared = bus_i.rd && bus_i.addr == `TSCW_OFF_SHARED;

    function automatic logic hit(input tscw_pkg::tscw_bus_t b, input logic [15:0] a);
        hit = b.wr && b.addr == a;
    endfunction

    // ==================================================================
    // slow clock source
    logic slow_edge;
    always_ff @(posedge clock_i) begin
        if (rst_i || osc_enable) begin
            mdiv <= 12'h000;
        end else if (mclk_tick_i) begin
            mdiv <= (mdiv == 12'(MCLK_DIV - 1)) ? 12'h000 : mdiv + 12'h001;
        end
    end
    assign slow_edge = osc_enable ? slow_tick_i
        : (mclk_tick_i && mdiv == 12'(MCLK_DIV - 1));

    logic half_tick;
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            slow_div <= 16'h0000;
        end else if (slow_edge) begin
            slow_div <= (slow_div == 16'(HALF_TICK_SLOW - 1)) ? 16'h0000 : slow_div + 16'h0001;
        end
    end
    assign half_tick = slow_edge && slow_div == 16'(HALF_TICK_SLOW - 1);

    // ==================================================================
    // counter period
    logic [3:0] period_halves;
    always_comb begin
        unique case (timekeeping_control[`TSCW_BIT_PERIOD_HI:`TSCW_BIT_PERIOD_LO])
            2'b10: period_halves = 4'h1;
            2'b11: period_halves = 4'h4;
            default: period_halves = 4'h2;
        endcase
    end
    logic period_tick;
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            half_cnt_period <= 4'h0;
        end else if (half_tick) begin
            half_cnt_period <= period_tick ? 4'h0 : half_cnt_period + 4'h1;
        end
    end
    assign period_tick = half_tick && (half_cnt_period + 4'h1 >= period_halves);

    // ==================================================================
    // counter, trim accumulator, load
    logic [24:0] acc_sum;
    assign acc_sum = {1'b0, trim_accumulator} + {2'b00, trim_value[22:0]};
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            load_pending <= 1'b0;
        end else if (hit(bus_i, `TSCW_OFF_CTRL) && bus_i.wdata[`TSCW_BIT_LOAD]) begin
            load_pending <= 1'b1;
        end else if (slow_edge) begin
            load_pending <= 1'b0;
        end
    end
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            time_count <= 32'h0000_0000;
            trim_accumulator <= 24'h00_0000;
            trim_value <= 24'h00_0000;
        end else if (load_pending && slow_edge) begin
            time_count <= staged_count;
            trim_accumulator <= staged_acc;
            trim_value <= staged_trim;
        end else if (period_tick) begin
            trim_accumulator <= acc_sum[23:0];
            if (acc_sum[24] && !trim_value[`TSCW_TRIM_SIGN]) begin
                time_count <= time_count + 32'h0000_0002;
            end else if (acc_sum[24]) begin
                time_count <= time_count;
            end else begin
                time_count <= time_count + 32'h0000_0001;
            end
        end
    end
    // staged bytes, least significant first
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            staged_count <= 32'h0000_0000;
            staged_acc <= 24'h00_0000;
            staged_trim <= 24'h00_0000;
        end else if (bus_i.wr) begin
            for (int i = 0; i < 4; i++) begin
                if (bus_i.addr == `TSCW_OFF_CNT0 + 16'(i)) begin
                    staged_count[8*i +: 8] <= bus_i.wdata;
                end
            end
            for (int i = 0; i < 3; i++) begin
                if (bus_i.addr == `TSCW_OFF_ACC0 + 16'(i)) begin
                    staged_acc[8*i +: 8] <= bus_i.wdata;
                end
                if (bus_i.addr == `TSCW_OFF_TRIM0 + 16'(i)) begin
                    staged_trim[8*i +: 8] <= bus_i.wdata;
                end
            end
        end
    end

    // ==================================================================
    // control registers
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            timekeeping_control <= `TSCW_RST_CTRL;
            osc_enable <= 1'(`TSCW_RST_OSC);
        end else begin
            if (hit(bus_i, `TSCW_OFF_CTRL)) begin
                // load bit is self-clearing, not stored
                timekeeping_control <= {2'b00, 1'b0, bus_i.wdata[4:0]};
            end
            if (hit(bus_i, `TSCW_OFF_OSC)) begin
                osc_enable <= bus_i.wdata[0];
            end
        end
    end

    // ==================================================================
    // interrupt interval
    logic [3:0] irq_halves;
    always_comb begin
        unique case (timekeeping_control[`TSCW_BIT_INTERVAL_HI:0])
            3'b100: irq_halves = 4'h1;
            3'b101: irq_halves = 4'h4;
            3'b110: irq_halves = 4'h8;
            3'b111: irq_halves = 4'hf;
            default: irq_halves = 4'h2;
        endcase
    end
    logic irq_tick;
    logic [4:0] irq_next;
    assign irq_next = {1'b0, half_cnt_irq} + 5'h01;
    // eight seconds is 16 halves: wrap of the 4-bit counter marks it
    assign irq_tick = half_tick && (irq_halves == 4'hf ? irq_next[4]
        : irq_next[3:0] >= irq_halves);
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            half_cnt_irq <= 4'h0;
        end else if (half_tick) begin
            half_cnt_irq <= (irq_tick && irq_halves != 4'hf) ? 4'h0 : irq_next[3:0];
        end
    end

    // ==================================================================
    // shared enable/flag register
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            shared_event_enable_flags <= `TSCW_RST_SHARED;
        end else begin
            if (wr_shared) begin
                shared_event_enable_flags[7] <= bus_i.wdata[7];
                shared_event_enable_flags[`TSCW_BIT_RTC_IEN] <= bus_i.wdata[5];
                shared_event_enable_flags[`TSCW_BIT_USB_IEN] <= bus_i.wdata[3];
                shared_event_enable_flags[`TSCW_BIT_KP_IEN] <= bus_i.wdata[1];
            end
            // flags clear on read, event wins
            shared_event_enable_flags[`TSCW_BIT_RTC_FLAG] <= irq_tick
                || (shared_event_enable_flags[`TSCW_BIT_RTC_FLAG] && !rd_shared);
            shared_event_enable_flags[`TSCW_BIT_USB_FLAG] <= usb_event_i
                || (shared_event_enable_flags[`TSCW_BIT_USB_FLAG] && !rd_shared);
            shared_event_enable_flags[`TSCW_BIT_KP_FLAG] <= keypad_event_i
                || (shared_event_enable_flags[`TSCW_BIT_KP_FLAG] && !rd_shared);
            shared_event_enable_flags[6] <= 1'b0;
        end
    end
    assign ext_irq5_o = (shared_event_enable_flags[5] && shared_event_enable_flags[4])
        || (shared_event_enable_flags[3] && shared_event_enable_flags[2])
        || (shared_event_enable_flags[1] && shared_event_enable_flags[0]);
    assign powerdown_mux_ctrl_o = shared_event_enable_flags[`TSCW_BIT_PD_MUX];

    // ==================================================================
    // hardware watchdog, timed in slow-clock edges
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            wdog_state <= tscw_pkg::TSCW_IDLE;
            wdog_cnt <= 16'h0000;
            wdog_reset_o <= 1'b0;
        end else begin
            wdog_reset_o <= 1'b0;
            unique case (wdog_state)
                tscw_pkg::TSCW_IDLE: begin
                    wdog_cnt <= 16'h0000;
                    if (irq_tick && shared_event_enable_flags[`TSCW_BIT_RTC_IEN]) begin
                        wdog_state <= tscw_pkg::TSCW_ARMED;
                    end
                end
                tscw_pkg::TSCW_ARMED: begin
                    if (rd_shared || !shared_event_enable_flags[`TSCW_BIT_RTC_IEN]) begin
                        wdog_state <= tscw_pkg::TSCW_IDLE;
                    end else if (slow_edge) begin
                        wdog_cnt <= wdog_cnt + 16'h0001;
                        if (wdog_cnt == 16'(WDOG_SLOW - 1)) begin
                            wdog_state <= tscw_pkg::TSCW_FIRE;
                        end
                    end
                end
                tscw_pkg::TSCW_FIRE: begin
                    wdog_reset_o <= 1'b1;
                    wdog_state <= tscw_pkg::TSCW_IDLE;
                end
                default: wdog_state <= tscw_pkg::TSCW_IDLE;
            endcase
        end
    end

    // ==================================================================
    // read port, data one cycle after strobe
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else if (bus_i.rd) begin
            unique case (bus_i.addr)
                `TSCW_OFF_SHARED: rdata_o <= shared_event_enable_flags;
                `TSCW_OFF_CTRL: rdata_o <= {2'b00, load_pending, timekeeping_control[4:0]};
                `TSCW_OFF_CNT0: rdata_o <= time_count[7:0];
                `TSCW_OFF_CNT1: rdata_o <= time_count[15:8];
                `TSCW_OFF_CNT2: rdata_o <= time_count[23:16];
                `TSCW_OFF_CNT3: rdata_o <= time_count[31:24];
                `TSCW_OFF_ACC0: rdata_o <= trim_accumulator[7:0];
                `TSCW_OFF_ACC1: rdata_o <= trim_accumulator[15:8];
                `TSCW_OFF_ACC2: rdata_o <= trim_accumulator[23:16];
                `TSCW_OFF_TRIM0: rdata_o <= trim_value[7:0];
                `TSCW_OFF_TRIM1: rdata_o <= trim_value[15:8];
                `TSCW_OFF_TRIM2: rdata_o <= trim_value[23:16];
                `TSCW_OFF_OSC: rdata_o <= {7'h00, osc_enable};
                default: rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // ==================================================================
    // checks
    flag_on_tick_a: assert property (@(posedge clock_i) disable iff (rst_i)
        irq_tick |=> shared_event_enable_flags[4]) else $error("flag not set on tick");
    flag_read_clear_a: assert property (@(posedge clock_i) disable iff (rst_i)
        rd_shared && !irq_tick |=> !shared_event_enable_flags[4])
        else $error("flag not cleared by read");
    irq_line_a: assert property (@(posedge clock_i) disable iff (rst_i)
        shared_event_enable_flags[5] && shared_event_enable_flags[4] |-> ext_irq5_o)
        else $error("irq line low while pending");
    wdog_disabled_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !shared_event_enable_flags[5] |=> ##1 !wdog_reset_o)
        else $error("watchdog fired while masked");
    wdog_masked_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !shared_event_enable_flags[5] |=> wdog_state != tscw_pkg::TSCW_ARMED)
        else $error("watchdog armed while masked");
    wdog_fire_a: assert property (@(posedge clock_i) disable iff (rst_i)
        wdog_state == tscw_pkg::TSCW_ARMED && slow_edge && !rd_shared
        && shared_event_enable_flags[5] && wdog_cnt == 16'(WDOG_SLOW - 1)
        |=> ##1 wdog_reset_o) else $error("watchdog did not fire");
    irq_gated_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !shared_event_enable_flags[5] && !shared_event_enable_flags[3]
        && !shared_event_enable_flags[1] |-> !ext_irq5_o) else $error("irq while all masked");
    wdog_service_a: assert property (@(posedge clock_i) disable iff (rst_i)
        wdog_state == tscw_pkg::TSCW_ARMED && rd_shared |=> wdog_state == tscw_pkg::TSCW_IDLE)
        else $error("read did not service watchdog");
    count_plus_a: assert property (@(posedge clock_i) disable iff (rst_i)
        period_tick && !(load_pending && slow_edge) && acc_sum[24] && !trim_value[23]
        |=> time_count == $past(time_count) + 32'h0000_0002)
        else $error("positive trim did not add count");
    count_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
        period_tick && !(load_pending && slow_edge) && acc_sum[24] && trim_value[23]
        |=> $stable(time_count)) else $error("negative trim did not hold count");
    count_step_a: assert property (@(posedge clock_i) disable iff (rst_i)
        period_tick && !(load_pending && slow_edge) && !acc_sum[24]
        |=> time_count == $past(time_count) + 32'h0000_0001)
        else $error("counter did not advance");
    load_copy_a: assert property (@(posedge clock_i) disable iff (rst_i)
        load_pending && slow_edge && !(hit(bus_i, `TSCW_OFF_CTRL) && bus_i.wdata[5])
        |=> time_count == $past(staged_count) && !load_pending)
        else $error("staged load missed");
    acc_step_a: assert property (@(posedge clock_i) disable iff (rst_i)
        period_tick && !(load_pending && slow_edge)
        |=> trim_accumulator == $past(trim_accumulator) + {1'b0, $past(trim_value[22:0])})
        else $error("accumulator did not add trim");
    shared_reset_a: assert property (@(posedge clock_i)
        rst_i |=> shared_event_enable_flags == 8'h00) else $error("shared reg not zero");
endmodule // tscw_core

// file: verilog/tscw_pkg.sv
// types for the trimmed seconds counter with watchdog
package tscw_pkg;
    typedef enum logic [1:0] {
        TSCW_IDLE,
        TSCW_ARMED,
        TSCW_FIRE
    } tscw_wdog_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tscw_bus_t;
endpackage
